// File: lbec_ahb_slave.sv
// AHB-Lite slave front end for the register file
`timescale 1ns/10ps
`include "lbec_consts.svh"
module lbec_ahb_slave (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Register file side
  output lbec_pkg::lbec_regwr_t    regWr,
  output logic [7:0]               rdAddr,
  input  wire logic [31:0]         rdData
);
  import lbec_pkg::*;

  logic       addrTaken;
  logic       wrPend;
  logic       rdPend;
  logic [7:0] phaseAddr;

  // Only whole-word transfers are expected, so hsize is not decoded
  assign addrTaken = hsel && htrans[1] && hready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend    <= 1'b0;
      rdPend    <= 1'b0;
      phaseAddr <= 8'h00;
    end else begin
      wrPend <= addrTaken && hwrite;
      rdPend <= addrTaken && !hwrite;
      if (addrTaken) begin
        phaseAddr <= haddr[7:0];
      end
    end
  end

  // One wait state on reads so a write just before is already visible
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= `LBEC_WORD_ZERO;
    end else if (rdPend) begin
      hrdata <= rdData;
    end
  end

  assign hreadyout  = !rdPend;
  assign hresp      = 1'b0;
  assign rdAddr     = phaseAddr;
  assign regWr.en   = wrPend;
  assign regWr.addr = phaseAddr;
  assign regWr.data = hwdata;
endmodule : lbec_ahb_slave

// File: lbec_consts.svh
// Constants for the loopback lane error counter block
// Summary of operation
// - Lanes 0 to 3 error counts read from the low count register, lane 0 in bits 7:0 up to lane 3 in bits 31:24.
// - Lanes 4 to 7 error counts read from the high count register, lane 4 in bits 7:0 up to lane 7 in bits 31:24.
// - While a test runs, a lane that takes part counts one error for each cycle its receiver flags a decode or disparity error, up to 255.
// - Writing one to the start bit clears every lane error count to zero.
// - A lane count means something only when that lane's tested flag is one, and software ignores it otherwise.
// - A lane that took no part in the test reports a count of zero.
// - A lane is untested when it lies outside the configured width or has no receiver detected.
// - The tested flags in status bits 15:8 clear at start and set at test end for each lane whose count is valid.
`ifndef LBEC_CONSTS_SVH
`define LBEC_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define LBEC_OFF_CTRL     8'h08
`define LBEC_OFF_STAT     8'h0c
`define LBEC_OFF_ERR_LO   8'h10
`define LBEC_OFF_ERR_HI   8'h14
`define LBEC_OFF_IRQ_STAT 8'h18
`define LBEC_OFF_IRQ_MASK 8'h1c

// ==========================================================
// Field positions
`define LBEC_CTRL_START   0
`define LBEC_CTRL_STOP    1
`define LBEC_LANE_LSB     8
`define LBEC_LANE_MSB     15
`define LBEC_STAT_RUN     0
`define LBEC_IRQ_DONE     0
`define LBEC_IRQ_SAT      1

// ==========================================================
// Sizes and reset values
`define LBEC_LANES        8
`define LBEC_CNT_W        8
`define LBEC_CNT_MAX      8'hff
`define LBEC_CNT_ZERO     8'h00
`define LBEC_LANE_EN_RST  8'hff
`define LBEC_IRQ_W        2
`define LBEC_IRQ_ZERO     2'h0
`define LBEC_WORD_ZERO    32'h0000_0000

`endif

// File: lbec_lane_cnt.sv
// One saturating per-lane error counter
`timescale 1ns/10ps
`include "lbec_consts.svh"
module lbec_lane_cnt (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // Control
  input  wire logic                    clear,
  input  wire logic                    running,
  input  wire logic                    eligible,
  input  wire logic                    laneErr,
  // Result
  output logic [`LBEC_CNT_W-1:0]       count,
  output logic                         satHit
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `LBEC_CNT_ZERO;
    end else if (clear || !eligible) begin
      count <= `LBEC_CNT_ZERO;
    end else if (running && laneErr && count != `LBEC_CNT_MAX) begin
      count <= count + 8'h01;
    end
  end

  // Pulse on the step into saturation only
  assign satHit = running && eligible && !clear && laneErr && (count == (`LBEC_CNT_MAX - 8'h01));
endmodule : lbec_lane_cnt

// File: lbec_loop_partner.sv
// Behavioural far-end loopback partner driving the lane receiver inputs
`timescale 1ns/10ps
module lbec_loop_partner (
  // Clock
  input  wire logic        core_clk,
  // Lane receiver view
  output logic [7:0]       symErr,
  output logic [7:0]       dispErr,
  output logic [7:0]       rxDetected,
  // Test end pulse
  output logic             loopDone
);
  initial begin
    symErr = 8'h00;
    dispErr = 8'h00;
    rxDetected = 8'hff;
    loopDone = 1'b0;
  end

  // ==========================================================
  // Stimulus tasks, each driving just after a rising edge
  // Kind bit 0 flags decode errors, bit 1 disparity errors
  task automatic send_errors(input logic [7:0] mask, input int n, input logic [1:0] kind);
    repeat (n) begin
      @(posedge core_clk);
      symErr <= kind[0] ? mask : 8'h00;
      dispErr <= kind[1] ? mask : 8'h00;
    end
    @(posedge core_clk);
    symErr <= 8'h00;
    dispErr <= 8'h00;
  endtask : send_errors

  task automatic finish_test();
    @(posedge core_clk);
    loopDone <= 1'b1;
    @(posedge core_clk);
    loopDone <= 1'b0;
  endtask : finish_test

  // Lanes with no far receiver look absent to the device
  task automatic set_receivers(input logic [7:0] mask);
    @(posedge core_clk);
    rxDetected <= mask;
  endtask : set_receivers
endmodule : lbec_loop_partner

// File: lbec_pkg.sv
// Types shared by the loopback lane error counter block
package lbec_pkg;
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
  } lbec_regwr_t;

  typedef enum logic {
    LBEC_IDLE,
    LBEC_RUN
  } lbec_state_t;
endpackage : lbec_pkg

// File: lbec_top.sv
// Loopback test per-lane error counters with AHB-Lite registers
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "lbec_consts.svh"
module lbec_top (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  // Lane receivers, core clock domain
  input  wire logic [`LBEC_LANES-1:0]  symErr,
  input  wire logic [`LBEC_LANES-1:0]  dispErr,
  input  wire logic [`LBEC_LANES-1:0]  rxDetected,
  // Link trainer, core clock domain
  input  wire logic                    loopDone,
  // Interrupt
  output logic                         irq
);
  import lbec_pkg::*;

  // ==========================================================
  // Declarations
  lbec_regwr_t                    regWr;
  logic [7:0]                     rdAddr;
  logic [31:0]                    rdData;
  lbec_state_t                    state;
  lbec_state_t                    next_state;
  logic [`LBEC_LANES-1:0]         laneEnable;
  logic [`LBEC_LANES-1:0]         laneTested;
  logic [`LBEC_LANES-1:0]         eligible;
  logic [`LBEC_LANES-1:0]         laneErr;
  logic [`LBEC_LANES-1:0]         satHit;
  logic [`LBEC_CNT_W-1:0]         laneCnt [`LBEC_LANES];
  logic [`LBEC_IRQ_W-1:0]         irqStat;
  logic [`LBEC_IRQ_W-1:0]         irqMask;
  logic [`LBEC_IRQ_W-1:0]         irqSet;
  logic [`LBEC_IRQ_W-1:0]         irqClr;
  logic                           ctrlWr;
  logic                           startPulse;
  logic                           stopPulse;
  logic                           testEnd;
  logic                           running;

  // ==========================================================
  // Bus front end
  lbec_ahb_slave u_ahb (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regWr     (regWr),
    .rdAddr    (rdAddr),
    .rdData    (rdData)
  );

  // ==========================================================
  // Control decode
  assign ctrlWr     = regWr.en && (regWr.addr == `LBEC_OFF_CTRL);
  assign startPulse = ctrlWr && regWr.data[`LBEC_CTRL_START];
  assign stopPulse  = ctrlWr && regWr.data[`LBEC_CTRL_STOP] && !startPulse;
  assign running    = (state == LBEC_RUN);
  assign testEnd    = running && !startPulse && (stopPulse || loopDone);

  // Configured lanes with a far receiver take part
  assign eligible = laneEnable & rxDetected;
  assign laneErr  = symErr | dispErr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      laneEnable <= `LBEC_LANE_EN_RST;
    end else if (ctrlWr) begin
      laneEnable <= regWr.data[`LBEC_LANE_MSB:`LBEC_LANE_LSB];
    end
  end

  // ==========================================================
  // Test sequencer
  always_comb begin
    next_state = state;
    case (state)
      LBEC_IDLE: begin
        if (startPulse) begin
          next_state = LBEC_RUN;
        end
      end
      LBEC_RUN: begin
        if (testEnd) begin
          next_state = LBEC_IDLE;
        end
      end
      default: begin
        next_state = LBEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LBEC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Tested flags: cleared on start, captured at the end of the test
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      laneTested <= '0;
    end else if (startPulse) begin
      laneTested <= '0;
    end else if (testEnd) begin
      laneTested <= eligible;
    end
  end

  // ==========================================================
  // Lane counters
  for (genvar i = 0; i < `LBEC_LANES; i++) begin : g_lane
    lbec_lane_cnt u_cnt (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clear    (startPulse),
      .running  (running),
      .eligible (eligible[i]),
      .laneErr  (laneErr[i]),
      .count    (laneCnt[i]),
      .satHit   (satHit[i])
    );
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  assign irqSet = {(|satHit), testEnd};
  assign irqClr = (regWr.en && regWr.addr == `LBEC_OFF_IRQ_STAT) ? regWr.data[`LBEC_IRQ_W-1:0] : `LBEC_IRQ_ZERO;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat <= `LBEC_IRQ_ZERO;
    end else begin
      irqStat <= (irqStat & ~irqClr) | irqSet;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask <= `LBEC_IRQ_ZERO;
    end else if (regWr.en && regWr.addr == `LBEC_OFF_IRQ_MASK) begin
      irqMask <= regWr.data[`LBEC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irqStat & ~irqClr) | irqSet) & irqMask);
    end
  end

  // ==========================================================
  // Read mux, unmapped reads return zero
  always_comb begin
    rdData = `LBEC_WORD_ZERO;
    case (rdAddr)
      `LBEC_OFF_CTRL: begin
        rdData[`LBEC_CTRL_START]              = running;
        rdData[`LBEC_LANE_MSB:`LBEC_LANE_LSB] = laneEnable;
      end
      `LBEC_OFF_STAT: begin
        rdData[`LBEC_STAT_RUN]                = running;
        rdData[`LBEC_LANE_MSB:`LBEC_LANE_LSB] = laneTested;
      end
      `LBEC_OFF_ERR_LO: begin
        rdData = {laneCnt[3], laneCnt[2], laneCnt[1], laneCnt[0]};
      end
      `LBEC_OFF_ERR_HI: begin
        rdData = {laneCnt[7], laneCnt[6], laneCnt[5], laneCnt[4]};
      end
      `LBEC_OFF_IRQ_STAT: begin
        rdData[`LBEC_IRQ_W-1:0] = irqStat;
      end
      `LBEC_OFF_IRQ_MASK: begin
        rdData[`LBEC_IRQ_W-1:0] = irqMask;
      end
      default: begin
        rdData = `LBEC_WORD_ZERO;
      end
    endcase
  end

  // ==========================================================
  // Assertions
  logic rdLoPhase;
  logic rdHiPhase;
  assign rdLoPhase = !hreadyout && rdAddr == `LBEC_OFF_ERR_LO;
  assign rdHiPhase = !hreadyout && rdAddr == `LBEC_OFF_ERR_HI;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_err_lo_layout;
    rdLoPhase |=> hrdata == {$past(laneCnt[3]), $past(laneCnt[2]), $past(laneCnt[1]), $past(laneCnt[0])};
  endproperty
  a_err_lo_layout: assert property (p_err_lo_layout) else $error("Low count word mislaid");

  property p_err_hi_layout;
    rdHiPhase |=> hreadyout && hrdata[7:0] == $past(laneCnt[4]) && hrdata[31:24] == $past(laneCnt[7]);
  endproperty
  a_err_hi_layout: assert property (p_err_hi_layout) else $error("High count word mislaid");

  property p_count_step;
    running && !startPulse && eligible[0] && laneErr[0] && laneCnt[0] != `LBEC_CNT_MAX && $stable(eligible[0])
      |=> laneCnt[0] == $past(laneCnt[0]) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("Lane 0 missed an error");

  property p_start_clears;
    startPulse |=> laneCnt[0] == `LBEC_CNT_ZERO && laneCnt[7] == `LBEC_CNT_ZERO && laneTested == '0 && running;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("Start did not clear counts");

  property p_idle_zero;
    !eligible[7] |=> laneCnt[7] == `LBEC_CNT_ZERO;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("Untested lane shows a count");

  property p_untested_flag;
    testEnd && (!laneEnable[6] || !rxDetected[6]) |=> !laneTested[6] ##1 !laneTested[6] || $past(startPulse);
  endproperty
  a_untested_flag: assert property (p_untested_flag) else $error("Ineligible lane flagged tested");

  property p_tested_capture;
    testEnd |=> laneTested == $past(eligible) && !running;
  endproperty
  a_tested_capture: assert property (p_tested_capture) else $error("Tested flags not captured");

  property p_saturate;
    laneCnt[4] == `LBEC_CNT_MAX && eligible[4] && !startPulse |=> laneCnt[4] == `LBEC_CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("Lane 4 counter wrapped");

  property p_sat_irq;
    satHit[4] |=> irqStat[`LBEC_IRQ_SAT];
  endproperty
  a_sat_irq: assert property (p_sat_irq) else $error("Saturation not flagged");

  property p_restart_clears;
    startPulse && running |=> running && laneCnt[4] == `LBEC_CNT_ZERO && laneCnt[1] == `LBEC_CNT_ZERO;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("Restart did not clear counts");

  property p_idle_hold;
    !running && !startPulse && eligible[0] |=> laneCnt[0] == $past(laneCnt[0]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Idle lane count moved");

  property p_flags_hold;
    !testEnd && !startPulse |=> laneTested == $past(laneTested);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("Tested flags moved mid test");

  // ==========================================================
  // Bus, sequencer and interrupt checks
  property p_stop_ends;
    stopPulse && running |=> !running;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("Stop did not end the test");

  property p_read_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("Read data phase had no wait state");

  property p_wait_once;
    !hreadyout |=> hreadyout;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("Wait state lasted too long");

  property p_irq_quiet;
    irqMask == `LBEC_IRQ_ZERO |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("Masked interrupt raised");

  property p_done_set;
    testEnd |=> irqStat[`LBEC_IRQ_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("Test done not flagged");

  // Wide window: the long saturation run takes a few hundred cycles
  c_full_test: cover property (startPulse ##[1:300] testEnd);
  c_saturated: cover property (satHit[4]);
  c_restart:   cover property (startPulse && running);
  c_read_high: cover property (rdHiPhase ##1 hreadyout);
  c_irq:       cover property (irqStat[`LBEC_IRQ_DONE] && irq);
endmodule : lbec_top

// File: test_loopback_lane_error_counters.sv
// Self-checking bench for the loopback lane error counters
`timescale 1ns/10ps
`include "lbec_consts.svh"
module test_loopback_lane_error_counters;
  import lbec_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hreadyBus;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  symErr;
  logic [7:0]  dispErr;
  logic [7:0]  rxDetected;
  logic        loopDone;
  logic        irq;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  always #4 core_clk = ~core_clk;

  lbec_top dut_u (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyBus),
    .hreadyout (hreadyBus),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .symErr    (symErr),
    .dispErr   (dispErr),
    .rxDetected(rxDetected),
    .loopDone  (loopDone),
    .irq       (irq)
  );

  lbec_loop_partner partner_u (
    .core_clk  (core_clk),
    .symErr    (symErr),
    .dispErr   (dispErr),
    .rxDetected(rxDetected),
    .loopDone  (loopDone)
  );

  // ==========================================================
  // Reporting
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // A hung handshake ends here rather than spinning forever
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // AHB-Lite single word transfers, entered just after a rising edge
  task automatic bus_xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, addr};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hreadyBus !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge core_clk); while (hreadyBus !== 1'b1);
    rdata = hrdata;
    check("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask : bus_xfer

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] ignored;
    bus_xfer(addr, 1'b1, data, ignored);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus_xfer(addr, 1'b0, 32'h0000_0000, got);
    check(what, exp, got);
  endtask : rd

  // Irq is registered, so give it one edge before looking
  task automatic sample_irq(input logic exp);
    @(posedge core_clk);
    @(negedge core_clk);
    check("irq", {31'h0, exp}, {31'h0, irq});
    @(posedge core_clk);
  endtask : sample_irq

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd("ctrl", `LBEC_OFF_CTRL, 32'h0000_ff00);
    rd("stat", `LBEC_OFF_STAT, 32'h0000_0000);
    rd("errLo", `LBEC_OFF_ERR_LO, 32'h0000_0000);
    rd("errHi", `LBEC_OFF_ERR_HI, 32'h0000_0000);
    rd("irqStat", `LBEC_OFF_IRQ_STAT, 32'h0000_0000);
    rd("irqMask", `LBEC_OFF_IRQ_MASK, 32'h0000_0000);
    rd("unmapped", 8'h20, 32'h0000_0000);
    wr(`LBEC_OFF_ERR_HI, 32'hffff_ffff);
    rd("errHiReadOnly", `LBEC_OFF_ERR_HI, 32'h0000_0000);
    // Lane 6 lacks a receiver, lane 7 lies outside the width
    partner_u.set_receivers(8'h3f);
    wr(`LBEC_OFF_IRQ_MASK, 32'h0000_0001);
    wr(`LBEC_OFF_CTRL, 32'h0000_7f01);
    for (int i = 0; i < 8; i++) begin
      partner_u.send_errors(8'(1 << i), i + 1, 2'((i % 3) + 1));
    end
    rd("statRunning", `LBEC_OFF_STAT, 32'h0000_0001);
    partner_u.finish_test();
    // Counts are trusted only once the tested flags are seen
    rd("statTested", `LBEC_OFF_STAT, 32'h0000_3f00);
    rd("errLoCounts", `LBEC_OFF_ERR_LO, 32'h0403_0201);
    rd("errHiCounts", `LBEC_OFF_ERR_HI, 32'h0000_0605);
    rd("irqStatDone", `LBEC_OFF_IRQ_STAT, 32'h0000_0001);
    sample_irq(1'b1);
    wr(`LBEC_OFF_IRQ_STAT, 32'h0000_0001);
    sample_irq(1'b0);
    // Restart with every lane live, interrupts masked
    partner_u.set_receivers(8'hff);
    wr(`LBEC_OFF_IRQ_MASK, 32'h0000_0000);
    wr(`LBEC_OFF_CTRL, 32'h0000_ff01);
    rd("errLoCleared", `LBEC_OFF_ERR_LO, 32'h0000_0000);
    rd("errHiCleared", `LBEC_OFF_ERR_HI, 32'h0000_0000);
    rd("statCleared", `LBEC_OFF_STAT, 32'h0000_0001);
    // Start with stop set restarts a running test and clears it
    partner_u.send_errors(8'h02, 3, 2'h1);
    rd("errLoPre", `LBEC_OFF_ERR_LO, 32'h0000_0300);
    wr(`LBEC_OFF_CTRL, 32'h0000_ff03);
    rd("errLoRestart", `LBEC_OFF_ERR_LO, 32'h0000_0000);
    rd("statRestart", `LBEC_OFF_STAT, 32'h0000_0001);
    partner_u.send_errors(8'h10, 258, 2'h3);
    partner_u.send_errors(8'h01, 2, 2'h1);
    wr(`LBEC_OFF_CTRL, 32'h0000_ff02);
    rd("statStopped", `LBEC_OFF_STAT, 32'h0000_ff00);
    rd("errHiSat", `LBEC_OFF_ERR_HI, 32'h0000_00ff);
    rd("errLoTwo", `LBEC_OFF_ERR_LO, 32'h0000_0002);
    rd("irqStatBoth", `LBEC_OFF_IRQ_STAT, 32'h0000_0003);
    sample_irq(1'b0);
    wr(`LBEC_OFF_IRQ_MASK, 32'h0000_0003);
    sample_irq(1'b1);
    wr(`LBEC_OFF_IRQ_STAT, 32'h0000_0003);
    sample_irq(1'b0);
    // An end pulse while idle must leave results alone
    partner_u.finish_test();
    rd("statIdle", `LBEC_OFF_STAT, 32'h0000_ff00);
    rd("errHiHeld", `LBEC_OFF_ERR_HI, 32'h0000_00ff);
    print_verdict();
  end
endmodule : test_loopback_lane_error_counters
